// file: design/tlv_pkg.sv
package tlv_pkg;

  localparam int unsigned SRC_N = 5;

  // Source index, also the bit position in the enable and priority registers
  localparam int unsigned SRC_EXT_A = 0;
  localparam int unsigned SRC_TIMER_A = 1;
  localparam int unsigned SRC_EXT_B = 2;
  localparam int unsigned SRC_TIMER_B = 3;
  localparam int unsigned SRC_SERIAL = 4;

  // Register offsets
  localparam logic [3:0] OFS_ENABLE = 4'h0;
  localparam logic [3:0] OFS_PRIORITY = 4'h1;
  localparam logic [3:0] OFS_TIMER_CTL = 4'h2;
  localparam logic [3:0] OFS_SERIAL = 4'h3;
  localparam logic [3:0] OFS_STATUS = 4'h4;

  // Field positions
  localparam int unsigned EN_GLOBAL_BIT = 7;
  localparam int unsigned CTL_EXT_A_EDGE_BIT = 0;
  localparam int unsigned CTL_EXT_A_FLAG_BIT = 1;
  localparam int unsigned CTL_EXT_B_EDGE_BIT = 2;
  localparam int unsigned CTL_EXT_B_FLAG_BIT = 3;
  localparam int unsigned CTL_TIMER_A_FLAG_BIT = 5;
  localparam int unsigned CTL_TIMER_B_FLAG_BIT = 7;
  localparam int unsigned SER_RX_BIT = 0;
  localparam int unsigned SER_TX_BIT = 1;
  localparam int unsigned STAT_LOW_BIT = 0;
  localparam int unsigned STAT_HIGH_BIT = 1;

  // Values after reset
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [4:0] PRIORITY_RST = 5'h00;
  localparam logic [1:0] EDGE_RST = 2'h0;
  localparam logic [4:0] FLAGS_RST = 5'h00;

  // Vector of source i is VEC_BASE + i * VEC_STEP
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_STEP = 16'h0008;

endpackage : tlv_pkg

// file: design/tlv_irq_unit.sv
// Contract
// - Type bit per external input: 0 means low level requests, 1 means edge.
// - Edge mode sets flag when one sample is high and the next is low.
// - Vectoring clears an external flag only in edge mode.
// - Timer flag set by rollover, cleared by hardware when vectored.
// - Serial request is rx OR tx flag; never cleared by vectoring.
// - Software set or clear of any flag acts exactly like hardware; level-mode external requests follow the pin, not a written flag.
// - Per-source enable bits 4..0 plus global enable bit 7.
// - Two levels; high preempts low, nothing preempts high, low not low.
// - Pending requests at both levels: service the high one.
// - Same level: ext A, timer A, ext B, timer B, serial.
// - Flags sampled at the phase strobe, polled in the following cycle.
// - No call while equal or higher level routine is in progress.
// - Call only in the final machine cycle of the current instruction.
// - No call after return-from-irq or enable/priority register write.
// - Blocked requests are not remembered; every poll is new.
// - Call loads fixed vector 0003H + 8 per source; status word not saved.
// - Return-from-irq clears in-progress state of the current level.
// - Plain subroutine return leaves in-progress state set.
// - Call lasts two machine cycles; response 3 to 9 machine cycles.
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/10ps
module tlv_irq_unit
  import tlv_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic ext_request_pin_a_i,
  input wire logic ext_request_pin_b_i,
  input wire logic timer_a_rollover_i,
  input wire logic timer_b_rollover_i,
  input wire logic rx_done_set_i,
  input wire logic tx_done_set_i,
  input wire logic sample_phase_strobe_i,
  input wire logic final_cycle_i,
  input wire logic return_from_irq_insn_i,
  input wire logic ie_ip_write_i,
  input wire logic return_from_irq_insn_done_i,
  output logic call_req_o,
  output logic [15:0] call_vector_o,
  output logic call_level_o,
  output logic [1:0] in_progress_o
);

  function automatic logic [2:0] tlv_pick(input logic [SRC_N-1:0] m);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = SRC_N - 1; i >= 0; i--)
    begin
      if (m[i])
        idx = 3'(i);
    end
    return idx;
  endfunction : tlv_pick

  logic [7:0] enable_reg;
  logic [SRC_N-1:0] priority_reg;
  logic [1:0] edge_reg;
  logic [1:0] ext_flag_reg;
  logic [1:0] timer_flag_reg;
  logic rx_flag_reg;
  logic tx_flag_reg;
  logic [SRC_N-1:0] smp_reg;
  logic [1:0] pin_s1_reg;
  logic [1:0] pin_s2_reg;
  logic [1:0] pin_s3_reg;
  logic [1:0] pin_lvl_reg;
  logic [1:0] pin_prev_reg;
  logic [1:0] prog_reg;
  logic [7:0] rdata_reg;
  logic call_reg;
  logic [15:0] vector_reg;
  logic level_reg;

  logic [1:0] pin_now;
  logic [1:0] ext_edge;
  logic wr_ctl;
  logic wr_ser;
  logic [SRC_N-1:0] elig;
  logic [SRC_N-1:0] hi_req;
  logic [SRC_N-1:0] lo_req;
  logic hi_ok;
  logic lo_ok;
  logic call_go;
  logic call_lvl;
  logic [2:0] win;
  logic [SRC_N-1:0] win_oh;
  logic [SRC_N-1:0] req_next;

  assign pin_now = {ext_request_pin_b_i, ext_request_pin_a_i};
  assign wr_ctl = reg_wr_i && (reg_addr_i == OFS_TIMER_CTL);
  assign wr_ser = reg_wr_i && (reg_addr_i == OFS_SERIAL);

  // Pins are asynchronous; a level counts only once two stages agree
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pin_s1_reg <= 2'h3;
      pin_s2_reg <= 2'h3;
      pin_s3_reg <= 2'h3;
      pin_lvl_reg <= 2'h3;
    end
    else
    begin
      pin_s1_reg <= pin_now;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      for (int i = 0; i < 2; i++)
      begin
        if (pin_s2_reg[i] == pin_s3_reg[i])
          pin_lvl_reg[i] <= pin_s3_reg[i];
      end
    end
  end

  // One pin sample per machine cycle
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      pin_prev_reg <= 2'h3;
    else if (sample_phase_strobe_i)
      pin_prev_reg <= pin_lvl_reg;
  end

  assign ext_edge = pin_prev_reg & ~pin_lvl_reg;

  // Enable and priority registers
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      enable_reg <= ENABLE_RST;
      priority_reg <= PRIORITY_RST;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == OFS_ENABLE)
      begin
        enable_reg[EN_GLOBAL_BIT] <= reg_wdata_i[EN_GLOBAL_BIT];
        enable_reg[SRC_N-1:0] <= reg_wdata_i[SRC_N-1:0];
      end
      // Upper bits are not stored, so stray ones do no harm here
      if (reg_addr_i == OFS_PRIORITY)
        priority_reg <= reg_wdata_i[SRC_N-1:0];
    end
  end

  // Poll: eligible requests from the previous cycle's samples
  always_comb
  begin
    elig = smp_reg & enable_reg[SRC_N-1:0]
         & {SRC_N{enable_reg[EN_GLOBAL_BIT]}};
    hi_req = elig & priority_reg;
    lo_req = elig & ~priority_reg;
    hi_ok = !prog_reg[STAT_HIGH_BIT] && (hi_req != '0);
    lo_ok = (prog_reg == 2'h0) && (lo_req != '0);
    call_lvl = hi_ok;
    if (hi_ok)
      win = tlv_pick(hi_req);
    else
      win = tlv_pick(lo_req);
    // No pending memory: a blocked poll simply yields nothing
    call_go = sample_phase_strobe_i && final_cycle_i
      && !return_from_irq_insn_i && !ie_ip_write_i
      && (hi_ok || lo_ok);
    win_oh = '0;
    if (call_go)
      win_oh[win] = 1'b1;
  end

  // Edge type bits and external flags
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      edge_reg <= EDGE_RST;
    else if (wr_ctl)
    begin
      edge_reg[0] <= reg_wdata_i[CTL_EXT_A_EDGE_BIT];
      edge_reg[1] <= reg_wdata_i[CTL_EXT_B_EDGE_BIT];
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      ext_flag_reg <= 2'h0;
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (!edge_reg[i] && sample_phase_strobe_i)
          ext_flag_reg[i] <= ~pin_lvl_reg[i];
        else if (edge_reg[i] && sample_phase_strobe_i && ext_edge[i])
          ext_flag_reg[i] <= 1'b1;
        else if (wr_ctl)
          ext_flag_reg[i] <= reg_wdata_i[i == 0 ? CTL_EXT_A_FLAG_BIT
                                                : CTL_EXT_B_FLAG_BIT];
        else if (edge_reg[i] && win_oh[i == 0 ? SRC_EXT_A : SRC_EXT_B])
          ext_flag_reg[i] <= 1'b0;
      end
    end
  end

  // Timer overflow flags; a rollover wins over any clear
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      timer_flag_reg <= 2'h0;
    else
    begin
      if (timer_a_rollover_i)
        timer_flag_reg[0] <= 1'b1;
      else if (wr_ctl)
        timer_flag_reg[0] <= reg_wdata_i[CTL_TIMER_A_FLAG_BIT];
      else if (win_oh[SRC_TIMER_A])
        timer_flag_reg[0] <= 1'b0;
      if (timer_b_rollover_i)
        timer_flag_reg[1] <= 1'b1;
      else if (wr_ctl)
        timer_flag_reg[1] <= reg_wdata_i[CTL_TIMER_B_FLAG_BIT];
      else if (win_oh[SRC_TIMER_B])
        timer_flag_reg[1] <= 1'b0;
    end
  end

  // Serial flags: only software clears them
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rx_flag_reg <= 1'b0;
      tx_flag_reg <= 1'b0;
    end
    else
    begin
      if (rx_done_set_i)
        rx_flag_reg <= 1'b1;
      else if (wr_ser)
        rx_flag_reg <= reg_wdata_i[SER_RX_BIT];
      if (tx_done_set_i)
        tx_flag_reg <= 1'b1;
      else if (wr_ser)
        tx_flag_reg <= reg_wdata_i[SER_TX_BIT];
    end
  end

  // Sample of every request, taken with the flag update of the same edge
  always_comb
  begin
    req_next[SRC_EXT_A] = edge_reg[0] ? (ext_flag_reg[0] || ext_edge[0])
                                      : ~pin_lvl_reg[0];
    req_next[SRC_EXT_B] = edge_reg[1] ? (ext_flag_reg[1] || ext_edge[1])
                                      : ~pin_lvl_reg[1];
    req_next[SRC_TIMER_A] = timer_flag_reg[0] || timer_a_rollover_i;
    req_next[SRC_TIMER_B] = timer_flag_reg[1] || timer_b_rollover_i;
    req_next[SRC_SERIAL] = rx_flag_reg || tx_flag_reg
                        || rx_done_set_i || tx_done_set_i;
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      smp_reg <= FLAGS_RST;
    else if (sample_phase_strobe_i)
      smp_reg <= req_next;
  end

  // In-progress levels
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      prog_reg <= 2'h0;
    else if (call_go)
      prog_reg[call_lvl ? STAT_HIGH_BIT : STAT_LOW_BIT] <= 1'b1;
    else if (return_from_irq_insn_done_i)
    begin
      // Only the irq return clears; a plain return never reaches here
      if (prog_reg[STAT_HIGH_BIT])
        prog_reg[STAT_HIGH_BIT] <= 1'b0;
      else
        prog_reg[STAT_LOW_BIT] <= 1'b0;
    end
  end

  // Call request to the core; the core pushes only the program counter
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      call_reg <= 1'b0;
      vector_reg <= VEC_BASE;
      level_reg <= 1'b0;
    end
    else
    begin
      call_reg <= call_go;
      if (call_go)
      begin
        vector_reg <= VEC_BASE + VEC_STEP * {13'h0000, win};
        level_reg <= call_lvl;
      end
    end
  end

  // Register reads
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rdata_reg <= 8'h00;
    else
    begin
      rdata_reg <= 8'h00;
      if (reg_rd_i)
      begin
        unique case (reg_addr_i)
          OFS_ENABLE: rdata_reg <= enable_reg;
          OFS_PRIORITY: rdata_reg <= {3'h0, priority_reg};
          OFS_TIMER_CTL:
          begin
            rdata_reg[CTL_EXT_A_EDGE_BIT] <= edge_reg[0];
            rdata_reg[CTL_EXT_A_FLAG_BIT] <= ext_flag_reg[0];
            rdata_reg[CTL_EXT_B_EDGE_BIT] <= edge_reg[1];
            rdata_reg[CTL_EXT_B_FLAG_BIT] <= ext_flag_reg[1];
            rdata_reg[CTL_TIMER_A_FLAG_BIT] <= timer_flag_reg[0];
            rdata_reg[CTL_TIMER_B_FLAG_BIT] <= timer_flag_reg[1];
          end
          OFS_SERIAL:
          begin
            rdata_reg[SER_RX_BIT] <= rx_flag_reg;
            rdata_reg[SER_TX_BIT] <= tx_flag_reg;
          end
          OFS_STATUS: rdata_reg <= {6'h00, prog_reg};
          default: rdata_reg <= 8'h00;
        endcase
      end
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign call_req_o = call_reg;
  assign call_vector_o = vector_reg;
  assign call_level_o = level_reg;
  assign in_progress_o = prog_reg;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  AST_EDGE_SETS_FLAG: assert property (
    sample_phase_strobe_i && edge_reg[0] && pin_prev_reg[0]
      && !pin_lvl_reg[0] |=> ext_flag_reg[0])
    else $error("edge did not set external flag");

  AST_LEVEL_FOLLOWS_PIN: assert property (
    sample_phase_strobe_i && !edge_reg[0] |=> ext_flag_reg[0]
      == !$past(pin_lvl_reg[0]))
    else $error("level flag does not follow pin");

  AST_TIMER_CLEARED: assert property (
    call_go && win == 3'(SRC_TIMER_A) && !timer_a_rollover_i && !wr_ctl
      |=> !timer_flag_reg[0] && call_req_o)
    else $error("timer flag not cleared on vectoring");

  AST_SERIAL_KEPT: assert property (
    call_go && rx_flag_reg && !wr_ser |=> rx_flag_reg)
    else $error("serial flag cleared by vectoring");

  AST_NO_CALL_UNDER_HIGH: assert property (
    call_req_o |-> !$past(prog_reg[STAT_HIGH_BIT])
      && ($past(prog_reg) == 2'h0 || level_reg))
    else $error("call issued under equal or higher level");

  AST_CALL_ON_FINAL: assert property (
    call_req_o |-> $past(sample_phase_strobe_i) && $past(final_cycle_i))
    else $error("call outside final cycle poll");

  AST_BLOCK_AFTER_RETURN_FROM_IRQ_INSN: assert property (
    return_from_irq_insn_i || ie_ip_write_i |=> !call_req_o)
    else $error("call after return or enable write");

  AST_RETURN_FROM_IRQ_INSN_CLEARS_HIGH: assert property (
    return_from_irq_insn_done_i && !call_go && prog_reg[STAT_HIGH_BIT]
      |=> !prog_reg[STAT_HIGH_BIT] ##1 prog_reg[STAT_LOW_BIT]
      == $past(prog_reg[STAT_LOW_BIT], 2) || $past(call_go))
    else $error("return did not clear high level");

  AST_FIXED_ORDER: assert property (
    call_go && !hi_ok && lo_req[SRC_EXT_A]
      |=> call_vector_o == VEC_BASE && !call_level_o)
    else $error("wrong vector for simultaneous requests");

  AST_HIGH_FIRST: assert property (
    call_go && hi_req != '0 |=> call_level_o)
    else $error("low level served before high");

  COV_HIGH_PREEMPTS: cover property (
    prog_reg == 2'h1 ##[1:200] call_req_o && call_level_o);
  COV_SERIAL_CALL: cover property (
    call_req_o && call_vector_o == VEC_BASE + 4 * VEC_STEP);
  COV_BLOCKED_THEN_LOST: cover property (
    sample_phase_strobe_i && !final_cycle_i && elig != '0
      ##1 elig == '0);

endmodule : tlv_irq_unit

// file: dv/tlv_core_model.sv
`timescale 1ns/10ps
module tlv_core_model (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic hold_i,
  input wire logic [1:0] blk_sel_i,
  input wire logic return_from_irq_insn_go_i,
  output logic strobe_o,
  output logic final_cycle_o,
  output logic rti_insn_o,
  output logic ie_ip_write_o,
  output logic return_from_irq_insn_done_o
);
  logic [1:0] phase_reg;
  logic [2:0] rti_reg;

  // Four clocks per machine cycle keep the run short
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      phase_reg <= 2'h0;
      rti_reg <= 3'h0;
      return_from_irq_insn_done_o <= 1'b0;
    end
    else
    begin
      phase_reg <= phase_reg + 2'h1;
      return_from_irq_insn_done_o <= return_from_irq_insn_go_i;
      // Return decode spans a whole machine cycle so one poll sees it
      rti_reg <= return_from_irq_insn_go_i ? 3'h7 : rti_reg - {2'h0, rti_reg != 3'h0};
    end
  end

  assign strobe_o = (phase_reg == 2'h3);
  assign final_cycle_o = !hold_i;
  assign rti_insn_o = (rti_reg != 3'h0) || (blk_sel_i == 2'h1);
  assign ie_ip_write_o = (blk_sel_i == 2'h2);
endmodule : tlv_core_model

// file: dv/two_level_vectored_irq_unit_tb.sv
`timescale 1ns/10ps
module two_level_vectored_irq_unit_tb;
  import tlv_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic pin_a = 1'b1;
  logic pin_b = 1'b1;
  logic [3:0] hw_set = 4'h0;
  logic hold = 1'b0;
  logic [1:0] blk = 2'h0;
  logic return_from_irq_insn_go = 1'b0;
  logic [7:0] rdata;
  logic call_req, call_lvl, stb, fin, rti, iew, rdone;
  logic [15:0] vec;
  logic [1:0] inprog;
  logic [16:0] e;
  int fail_count = 0;
  int samples_checked = 0;
  int ncalls = 0;
  int pend = 0;
  int en = 0;
  int prio = 0;
  int edge_bits = 0;
  int lvl = 0;
  int s, r;

  tlv_irq_unit u_dut (.core_clk_i(clk), .reset_n_i(rst_n),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .ext_request_pin_a_i(pin_a),
    .ext_request_pin_b_i(pin_b), .timer_a_rollover_i(hw_set[0]),
    .timer_b_rollover_i(hw_set[1]), .rx_done_set_i(hw_set[2]),
    .tx_done_set_i(hw_set[3]), .sample_phase_strobe_i(stb),
    .final_cycle_i(fin), .return_from_irq_insn_i(rti),
    .ie_ip_write_i(iew), .return_from_irq_insn_done_i(rdone), .call_req_o(call_req),
    .call_vector_o(vec), .call_level_o(call_lvl), .in_progress_o(inprog));

  tlv_core_model u_core (.core_clk_i(clk), .reset_n_i(rst_n),
    .hold_i(hold), .blk_sel_i(blk), .return_from_irq_insn_go_i(return_from_irq_insn_go), .strobe_o(stb),
    .final_cycle_o(fin), .rti_insn_o(rti), .ie_ip_write_o(iew),
    .return_from_irq_insn_done_o(rdone));

  always #4 clk = ~clk;

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  task automatic chk_reg(input logic [7:0] g, input logic [7:0] x);
    samples_checked++;
    if (g !== x)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk_reg

  task automatic chk_call(input logic [16:0] g, input logic [16:0] x);
    samples_checked++;
    if (g !== x)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk_call

  // Highest level wins, then lowest source index; must beat running level
  function automatic int pick();
    int best = -1;
    for (int i = 0; i < 5; i++)
      if (pend[i] && en[i] && en[7] && prio[i] + 1 > (lvl[1] ? 2 : lvl))
        if (best < 0 || prio[i] > prio[best])
          best = i;
    return best;
  endfunction : pick

  always @(posedge clk)
  begin
    if (call_req === 1'b1)
    begin
      s = pick();
      ncalls++;
      e = (s < 0) ? 17'h1FFFF : {prio[s], 16'(VEC_BASE + VEC_STEP * s)};
      chk_call({call_lvl, vec}, e);
      if (s >= 0)
      begin
        lvl = lvl | (prio[s] ? 2 : 1);
        if (s == 1 || s == 3 || (s == 0 && edge_bits[0]))
          pend[s] = 0;
        if (s == 2 && edge_bits[1])
          pend[s] = 0;
      end
    end
  end

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] x);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk_reg(rdata, x);
  endtask : rd_chk

  task automatic pulse(input int i);
    @(posedge clk);
    hw_set[i] <= 1'b1;
    @(posedge clk);
    hw_set <= 4'h0;
  endtask : pulse

  task automatic wait_call(input int lim);
    int c0 = ncalls;
    for (int k = 0; k < lim && ncalls == c0; k++)
    begin
      @(posedge clk);
      #1;
    end
    if (ncalls == c0)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, 0, 1);
      report_and_stop();
    end
  endtask : wait_call

  task automatic no_call(input int n);
    int c0 = ncalls;
    repeat (n) @(posedge clk);
    #1;
    chk_reg(8'(ncalls), 8'(c0));
  endtask : no_call

  task automatic return_from_irq_insn();
    @(posedge clk);
    return_from_irq_insn_go <= 1'b1;
    @(posedge clk);
    return_from_irq_insn_go <= 1'b0;
    lvl = lvl[1] ? (lvl & 1) : 0;
  endtask : return_from_irq_insn

  initial
  begin
    void'($urandom(80434));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++)
      rd_chk(4'(i), 8'h00);
    rd_chk(4'hF, 8'h00);
    wr_reg(OFS_ENABLE, 8'hFF);
    en = 8'h9F;
    rd_chk(OFS_ENABLE, 8'h9F);
    // Pin a edge, pin b level; pins held a machine cycle or more
    wr_reg(OFS_TIMER_CTL, 8'h01);
    edge_bits = 1;
    @(posedge clk);
    pin_a <= 1'b0;
    pend = 1;
    wait_call(40);
    rd_chk(OFS_TIMER_CTL, 8'h01);
    rd_chk(OFS_STATUS, 8'h01);
    return_from_irq_insn();
    rd_chk(OFS_STATUS, 8'h00);
    @(posedge clk);
    pin_b <= 1'b0;
    pend = 4;
    wait_call(40);
    rd_chk(OFS_TIMER_CTL, 8'h09);
    no_call(40);
    pin_b <= 1'b1;
    repeat (16) @(posedge clk);
    pend = 0;
    return_from_irq_insn();
    no_call(60);
    pulse(0);
    pend = 2;
    wait_call(40);
    rd_chk(OFS_TIMER_CTL, 8'h01);
    pulse(1);
    pend = pend | 8;
    no_call(40);
    wr_reg(OFS_PRIORITY, 8'h10);
    prio = 16;
    pulse(2);
    pend = pend | 16;
    wait_call(40);
    rd_chk(OFS_SERIAL, 8'h01);
    wr_reg(OFS_SERIAL, 8'h00);
    pend = pend & 15;
    wr_reg(OFS_PRIORITY, 8'h11);
    prio = 17;
    wr_reg(OFS_TIMER_CTL, 8'h83);
    pend = pend | 1;
    no_call(40);
    return_from_irq_insn();
    wait_call(80);
    return_from_irq_insn();
    no_call(40);
    return_from_irq_insn();
    wait_call(80);
    return_from_irq_insn();
    // Blocked requests are dropped once the flag goes away
    hold <= 1'b1;
    pulse(0);
    pend = 2;
    no_call(40);
    wr_reg(OFS_TIMER_CTL, 8'h01);
    pend = 0;
    // Let two strobes resample the cleared flag before polls may call
    repeat (8) @(posedge clk);
    hold <= 1'b0;
    no_call(40);
    blk <= 2'h2;
    pulse(0);
    pend = 2;
    no_call(40);
    blk <= 2'h0;
    wait_call(40);
    return_from_irq_insn();
    wr_reg(OFS_ENABLE, 8'h1F);
    en = 8'h1F;
    pulse(3);
    pend = 16;
    no_call(40);
    wr_reg(OFS_ENABLE, 8'h9F);
    en = 8'h9F;
    wait_call(40);
    wr_reg(OFS_SERIAL, 8'h00);
    pend = 0;
    return_from_irq_insn();
    edge_bits = 3;
    for (int n = 0; n < 12; n++)
    begin
      r = $urandom;
      wr_reg(OFS_ENABLE, 8'h00);
      en = 0;
      wr_reg(OFS_PRIORITY, {3'h0, r[4:0]});
      prio = r[4:0];
      wr_reg(OFS_TIMER_CTL, {r[8], 1'b0, r[6], 1'b0, r[7], 1'b1, r[5], 1'b1});
      wr_reg(OFS_SERIAL, {6'h00, r[10], r[9]});
      pend = r[8:5] | ((r[9] | r[10]) << 4);
      wr_reg(OFS_ENABLE, {3'h4, r[15:11]});
      en = 128 | r[15:11];
      while ((pend & en & 31) != 0)
      begin
        wait_call(60);
        if (vec === 16'h0023)
        begin
          wr_reg(OFS_SERIAL, 8'h00);
          pend = pend & 15;
        end
        return_from_irq_insn();
      end
      wr_reg(OFS_TIMER_CTL, 8'h05);
      wr_reg(OFS_SERIAL, 8'h00);
      pend = 0;
      rd_chk(OFS_STATUS, 8'h00);
      chk_reg({6'h00, inprog}, 8'h00);
    end
    report_and_stop();
  end
endmodule : two_level_vectored_irq_unit_tb
